//--- hdl/lds_pkg.sv
package lds_pkg;

  // ==========================================================
  // Register map (byte addresses, one word each)
  localparam logic [4:0] LDS_OFS_CTRL = 5'h00;
  localparam logic [4:0] LDS_OFS_TRAVEL = 5'h04;
  localparam logic [4:0] LDS_OFS_AFTERRUN = 5'h08;
  localparam logic [4:0] LDS_OFS_VALVE_DLY = 5'h0C;
  localparam logic [4:0] LDS_OFS_PUMP_DLY = 5'h10;
  localparam logic [4:0] LDS_OFS_STATUS = 5'h14;

  // ==========================================================
  // Widths and reset values
  localparam int LDS_MS_W = 16;
  localparam int LDS_SIG_W = 8;
  localparam logic [8:0] LDS_CTRL_RST = 9'h000;
  localparam logic [4:0] LDS_TRAVEL_RST = 5'h00;
  localparam logic [15:0] LDS_DLY_RST = 16'h0000;

  // ==========================================================
  // Timing
  localparam longint LDS_CLK_HZ = 250000000;
  localparam longint LDS_MS_PER_S = 1000;
  localparam int LDS_CYC_PER_MS = int'(LDS_CLK_HZ / LDS_MS_PER_S);

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    LDS_CREEP, LDS_SLOW, LDS_MEDIUM, LDS_INTERMEDIATE,
    LDS_RATED, LDS_INSPECTION, LDS_EMERGENCY, LDS_RELEVEL
  } lds_speed_e;

  typedef enum logic [1:0] {
    LDS_ROLE_SOFTSTART, LDS_ROLE_STAR_DELTA, LDS_ROLE_INV_POWER, LDS_ROLE_PRIMARY_UP
  } lds_role_e;

  typedef struct packed {
    logic pump_en_use;
    logic vel_en_use;
    logic ready_use;
    logic ramp_use;
    logic relay5_use;
    lds_role_e role;
    logic second_enc;
    logic hydraulic;
  } lds_ctrl_s;

  typedef struct packed {
    lds_speed_e speed;
    logic down;
    logic up;
  } lds_travel_s;

  typedef struct packed {
    logic up;
    logic down;
    logic fast;
    logic slow_pump;
    logic star;
  } lds_relay_s;

endpackage : lds_pkg

//--- hdl/lds_ms_timer.sv
module lds_ms_timer #(
  parameter int W = 16
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic tick_ms,
  input wire logic run,
  input wire logic [W-1:0] delay_ms,
  output logic hold
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // ==========================================================
  // Reload while running, count down in whole ms after release
  // Release may fall mid-millisecond, so the hold is up to 1 ms short
  assign cnt_d = run ? delay_ms :
                 (tick_ms && cnt_q != '0) ? cnt_q - W'(1) : cnt_q;
  assign hold = (cnt_q != '0);

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) cnt_q <= '0;
    else cnt_q <= cnt_d;
  end

endmodule : lds_ms_timer

//--- hdl/lds_valve_enc.sv
module lds_valve_enc (
  input wire logic up,
  input wire logic down,
  input wire logic second_enc,
  input wire lds_pkg::lds_speed_e speed,
  output logic [7:0] sig
);

  // Signal n sits in bit n-1
  function automatic logic [7:0] bit_of(input int n);
    bit_of = 8'h01 << (n - 1);
  endfunction : bit_of

  wire dir_any = up ^ down;
  wire [7:0] dir_sig = up ? bit_of(7) : bit_of(8);
  wire [7:0] fast_sig = up ? bit_of(5) : bit_of(6);
  wire insp = (speed == lds_pkg::LDS_INSPECTION) || (speed == lds_pkg::LDS_EMERGENCY);
  wire dir_only = (speed == lds_pkg::LDS_CREEP) || (speed == lds_pkg::LDS_RELEVEL);
  wire [7:0] first_add = (speed == lds_pkg::LDS_SLOW) ? bit_of(1) :
                         (speed == lds_pkg::LDS_MEDIUM) ? bit_of(2) :
                         (speed == lds_pkg::LDS_INTERMEDIATE) ? bit_of(3) :
                         insp ? bit_of(4) : 8'h00;
  wire [7:0] first_sig = dir_only ? dir_sig : (dir_sig | fast_sig | first_add);
  wire [7:0] second_sig = dir_only ? dir_sig :
                          (speed == lds_pkg::LDS_SLOW) ? (dir_sig | bit_of(3)) :
                          insp ? (dir_sig | bit_of(4)) : (dir_sig | fast_sig);

  assign sig = !dir_any ? 8'h00 : (second_enc ? second_sig : first_sig);

endmodule : lds_valve_enc

//--- hdl/lds_mapper.sv
// Function
// - Relays: up, down, fast, slow
// - Pole-changing motor drives no control signals
// - Drive-enabled holds for afterrun after release
// - Hydraulic relay four follows pump role
// - Optional fifth relay drives star contactor
// - Ramp option holds valves until ramp-up
// - Readiness input monitored as drive fault
// - Slow upward valve with delayed off
// - Pump delayed off only after upward
// - Delays in ms, zero after reset
// - First encoding: 7 up, 8 down
// - First encoding speed adds 5/6 plus 1-4
// - Supervision feedback read back in status register
// - Second encoding: direction plus 3/5/6/4
// - Pump-enable input honoured only when enabled
// - Enable input gates valve signals
// - Drive-enabled rises before direction signals
module lds_mapper #(
  parameter int CYC_PER_MS = lds_pkg::LDS_CYC_PER_MS
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic RAMP_UP_DONE,
  input wire logic DRIVE_READY,
  input wire logic CTRL_ENABLE,
  input wire logic VALVE_SUPERVISION_FEEDBACK,
  input wire logic VALVE_READY_STATE,
  input wire logic PUMP_ENABLE,
  output logic PILOT_RELAY_UP,
  output logic PILOT_RELAY_DOWN,
  output logic PILOT_RELAY_FAST,
  output logic PILOT_RELAY_SLOW_OR_PUMP_ROLE,
  output logic QUICKSTART_RELAY,
  output logic DRIVE_ENABLED,
  output logic SLOW_UP_VALVE,
  output logic [7:0] CTRL_SIG
);

  // ==========================================================
  // Register bus
  lds_pkg::lds_ctrl_s ctrl_q;
  lds_pkg::lds_travel_s travel_q;
  logic [15:0] afterrun_q;
  logic [15:0] valve_dly_q;
  logic [15:0] pump_dly_q;
  logic fault_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic fault_d;

  wire req = AVS_READ || AVS_WRITE;
  wire acc = req && ack_q;
  wire wr = AVS_WRITE && ack_q;

  // One wait state: the read word is registered during it
  assign AVS_WAITREQUEST = req && !ack_q;
  assign AVS_READDATA = rdata_q;

  function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] be);
    merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  wire wr_ctrl = wr && hit(AVS_ADDRESS, lds_pkg::LDS_OFS_CTRL);
  wire wr_travel = wr && hit(AVS_ADDRESS, lds_pkg::LDS_OFS_TRAVEL);
  wire wr_after = wr && hit(AVS_ADDRESS, lds_pkg::LDS_OFS_AFTERRUN);
  wire wr_valve = wr && hit(AVS_ADDRESS, lds_pkg::LDS_OFS_VALVE_DLY);
  wire wr_pump = wr && hit(AVS_ADDRESS, lds_pkg::LDS_OFS_PUMP_DLY);
  wire wr_status = wr && hit(AVS_ADDRESS, lds_pkg::LDS_OFS_STATUS);
  wire [15:0] ctrl_m = merge16({7'h00, ctrl_q}, AVS_WRITEDATA, AVS_BYTEENABLE);
  wire [8:0] ctrl_w = ctrl_m[8:0];
  wire [4:0] travel_w = AVS_BYTEENABLE[0] ? AVS_WRITEDATA[4:0] : travel_q;

  // ==========================================================
  // Travel state
  logic drive_en_q;
  logic relay_up_q;
  logic relay_down_q;
  logic relay_fast_q;
  logic relay4_q;
  logic star_q;
  logic slow_valve_q;
  logic [7:0] sig_q;
  logic after_hold;
  logic valve_hold;
  logic pump_hold;
  logic [7:0] enc_sig;
  logic [$clog2(CYC_PER_MS)-1:0] pre_q;
  logic tick_ms;

  // Fault from a drive that reports readiness blocks all travel
  wire ready_fault = ctrl_q.ready_use && !DRIVE_READY;
  // Both directions at once counts as no travel
  wire want_up = travel_q.up && !travel_q.down && !ready_fault;
  wire want_down = travel_q.down && !travel_q.up && !ready_fault;
  wire want = want_up || want_down;
  // Direction contactors only after the enable output stood a cycle
  wire go_up = want_up && drive_en_q;
  wire go_down = want_down && drive_en_q;
  wire go = go_up || go_down;
  wire spd_fast = (travel_q.speed == lds_pkg::LDS_MEDIUM) ||
                  (travel_q.speed == lds_pkg::LDS_INTERMEDIATE) ||
                  (travel_q.speed == lds_pkg::LDS_RATED);
  wire hyd = ctrl_q.hydraulic;

  // Pump runs for upward travel only, plus its delayed-off time
  wire pump_on = hyd && (go_up || pump_hold);
  wire delta_on = pump_on && RAMP_UP_DONE;
  wire relay4_hyd = (ctrl_q.role == lds_pkg::LDS_ROLE_SOFTSTART) ? pump_on :
                    (ctrl_q.role == lds_pkg::LDS_ROLE_STAR_DELTA) ? delta_on :
                    (ctrl_q.role == lds_pkg::LDS_ROLE_INV_POWER) ? go : pump_on;
  wire relay4_d = hyd ? relay4_hyd : (go && !spd_fast);
  wire star_d = hyd && ctrl_q.relay5_use &&
                (ctrl_q.role == lds_pkg::LDS_ROLE_STAR_DELTA) && pump_on && !delta_on;

  // Valve release gates: ramp-up, enable and pump enable for upward
  wire ramp_ok = !ctrl_q.ramp_use || RAMP_UP_DONE;
  wire enable_ok = !ctrl_q.vel_en_use || CTRL_ENABLE;
  wire pump_ok = !ctrl_q.pump_en_use || !go_up || PUMP_ENABLE;
  wire valves_ok = ramp_ok && enable_ok && pump_ok;
  wire [7:0] sig_d = (hyd && go && valves_ok) ? enc_sig : 8'h00;
  wire slow_run = hyd && go_up && valves_ok;
  wire slow_valve_d = ramp_ok && (slow_run || valve_hold);

  wire drive_en_d = want || after_hold;
  assign fault_d = ready_fault || (fault_q && !(wr_status && AVS_BYTEENABLE[0] && AVS_WRITEDATA[0]));

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (AVS_ADDRESS)
      lds_pkg::LDS_OFS_CTRL: rdata_d = {23'h000000, ctrl_q};
      lds_pkg::LDS_OFS_TRAVEL: rdata_d = {27'h0000000, travel_q};
      lds_pkg::LDS_OFS_AFTERRUN: rdata_d = {16'h0000, afterrun_q};
      lds_pkg::LDS_OFS_VALVE_DLY: rdata_d = {16'h0000, valve_dly_q};
      lds_pkg::LDS_OFS_PUMP_DLY: rdata_d = {16'h0000, pump_dly_q};
      lds_pkg::LDS_OFS_STATUS: rdata_d = {20'h00000, sig_q, pump_on, VALVE_READY_STATE,
                                          VALVE_SUPERVISION_FEEDBACK, fault_q};
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // Millisecond prescaler and timers
  assign tick_ms = (pre_q == ($clog2(CYC_PER_MS))'(CYC_PER_MS - 1));

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) pre_q <= '0;
    else pre_q <= tick_ms ? '0 : pre_q + 1'b1;
  end

  lds_ms_timer #(.W(lds_pkg::LDS_MS_W)) u_after (
    .CLK(CLK), .RST_B(RST_B), .tick_ms(tick_ms), .run(go),
    .delay_ms(afterrun_q), .hold(after_hold));
  lds_ms_timer #(.W(lds_pkg::LDS_MS_W)) u_valve (
    .CLK(CLK), .RST_B(RST_B), .tick_ms(tick_ms), .run(slow_run),
    .delay_ms(valve_dly_q), .hold(valve_hold));
  lds_ms_timer #(.W(lds_pkg::LDS_MS_W)) u_pump (
    .CLK(CLK), .RST_B(RST_B), .tick_ms(tick_ms), .run(hyd && go_up),
    .delay_ms(pump_dly_q), .hold(pump_hold));

  lds_valve_enc u_enc (
    .up(go_up), .down(go_down), .second_enc(ctrl_q.second_enc),
    .speed(travel_q.speed), .sig(enc_sig));

  // ==========================================================
  // Registers
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= req && !ack_q;
      rdata_q <= (AVS_READ && !ack_q) ? rdata_d : rdata_q;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_q <= lds_pkg::lds_ctrl_s'(lds_pkg::LDS_CTRL_RST);
      travel_q <= lds_pkg::lds_travel_s'(lds_pkg::LDS_TRAVEL_RST);
      afterrun_q <= lds_pkg::LDS_DLY_RST;
      valve_dly_q <= lds_pkg::LDS_DLY_RST;
      pump_dly_q <= lds_pkg::LDS_DLY_RST;
      fault_q <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_q <= lds_pkg::lds_ctrl_s'(ctrl_w);
      if (wr_travel) travel_q <= lds_pkg::lds_travel_s'(travel_w);
      if (wr_after) afterrun_q <= merge16(afterrun_q, AVS_WRITEDATA, AVS_BYTEENABLE);
      if (wr_valve) valve_dly_q <= merge16(valve_dly_q, AVS_WRITEDATA, AVS_BYTEENABLE);
      if (wr_pump) pump_dly_q <= merge16(pump_dly_q, AVS_WRITEDATA, AVS_BYTEENABLE);
      fault_q <= fault_d;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      drive_en_q <= 1'b0;
      relay_up_q <= 1'b0;
      relay_down_q <= 1'b0;
      relay_fast_q <= 1'b0;
      relay4_q <= 1'b0;
      star_q <= 1'b0;
      slow_valve_q <= 1'b0;
      sig_q <= 8'h00;
    end else begin
      drive_en_q <= drive_en_d;
      relay_up_q <= go_up;
      relay_down_q <= go_down;
      relay_fast_q <= go && spd_fast;
      relay4_q <= relay4_d;
      star_q <= star_d;
      slow_valve_q <= slow_valve_d;
      sig_q <= sig_d;
    end
  end

  assign PILOT_RELAY_UP = relay_up_q;
  assign PILOT_RELAY_DOWN = relay_down_q;
  assign PILOT_RELAY_FAST = relay_fast_q;
  assign PILOT_RELAY_SLOW_OR_PUMP_ROLE = relay4_q;
  assign QUICKSTART_RELAY = star_q;
  assign DRIVE_ENABLED = drive_en_q;
  assign SLOW_UP_VALVE = slow_valve_q;
  assign CTRL_SIG = sig_q;

endmodule : lds_mapper

//--- dv/lds_checker.sv
module lds_checker (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic RAMP_UP_DONE,
  input wire logic CTRL_ENABLE,
  input wire logic PILOT_RELAY_UP,
  input wire logic PILOT_RELAY_DOWN,
  input wire logic DRIVE_ENABLED,
  input wire logic [7:0] CTRL_SIG
);
  // ==========
  // Shadow of control and travel writes
  logic [7:0] ctrl_q;
  logic [1:0] trav_q;
  wire logic wr_ok = AVS_WRITE & ~AVS_WAITREQUEST;
  // Both or neither direction counts as no travel
  wire logic idle = ~^trav_q;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_q <= 8'h00;
      trav_q <= 2'h0;
    end else if (wr_ok) begin
      if (AVS_ADDRESS == lds_pkg::LDS_OFS_CTRL) ctrl_q <= AVS_WRITEDATA[7:0];
      if (AVS_ADDRESS == lds_pkg::LDS_OFS_TRAVEL) trav_q <= AVS_WRITEDATA[1:0];
    end
  end
  // ==========
  // Properties
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  property p_excl; !(PILOT_RELAY_UP && PILOT_RELAY_DOWN) && !(CTRL_SIG[6] && CTRL_SIG[7]); endproperty
  a_excl: assert property (p_excl) else $error("up and down together");
  property p_pole; !ctrl_q[0] && !$past(ctrl_q[0]) |-> CTRL_SIG == 8'h00; endproperty
  a_pole: assert property (p_pole) else $error("control signals on pole-changing motor");
  property p_first; $rose(PILOT_RELAY_UP) || $rose(PILOT_RELAY_DOWN) || $rose(|CTRL_SIG) |-> $past(DRIVE_ENABLED); endproperty
  a_first: assert property (p_first) else $error("direction before drive enabled");
  property p_dir; (!CTRL_SIG[6] || PILOT_RELAY_UP) && (!CTRL_SIG[7] || PILOT_RELAY_DOWN); endproperty
  a_dir: assert property (p_dir) else $error("direction signal without relay");
  property p_up_fast; CTRL_SIG[4] |-> CTRL_SIG[6] && !CTRL_SIG[5]; endproperty
  a_up_fast: assert property (p_up_fast) else $error("signal 5 without upward");
  property p_dn_fast; CTRL_SIG[5] |-> CTRL_SIG[7]; endproperty
  a_dn_fast: assert property (p_dn_fast) else $error("signal 6 without downward");
  property p_ramp; ctrl_q[5] && $past(ctrl_q[5]) && !$past(RAMP_UP_DONE) |-> CTRL_SIG == 8'h00; endproperty
  a_ramp: assert property (p_ramp) else $error("valves before ramp-up");
  property p_en; ctrl_q[7] && $past(ctrl_q[7]) && !$past(CTRL_ENABLE) |-> CTRL_SIG == 8'h00; endproperty
  a_en: assert property (p_en) else $error("valves before enable");
  property p_idle; idle && $past(idle) |-> CTRL_SIG == 8'h00 && !PILOT_RELAY_UP && !PILOT_RELAY_DOWN; endproperty
  a_idle: assert property (p_idle) else $error("outputs left on when idle");
endmodule : lds_checker

bind lds_mapper lds_checker u_chk (.CLK(CLK), .RST_B(RST_B), .AVS_ADDRESS(AVS_ADDRESS), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .RAMP_UP_DONE(RAMP_UP_DONE),
  .CTRL_ENABLE(CTRL_ENABLE), .PILOT_RELAY_UP(PILOT_RELAY_UP), .PILOT_RELAY_DOWN(PILOT_RELAY_DOWN),
  .DRIVE_ENABLED(DRIVE_ENABLED), .CTRL_SIG(CTRL_SIG));

//--- dv/lds_partner.sv
module lds_partner (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic run,
  input wire logic [7:0] sig,
  input wire logic fault,
  input wire logic pump_block,
  output logic ramp_done,
  output logic drive_ready,
  output logic ctrl_enable,
  output logic sup_fb,
  output logic valve_rdy,
  output logic pump_en
);
  logic [2:0] cnt_q;
  // ==========
  // Soft starter reaches speed seven cycles after the motor starts
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) cnt_q <= 3'h0;
    else if (!run) cnt_q <= 3'h0;
    else if (cnt_q != 3'h7) cnt_q <= cnt_q + 3'h1;
  end
  assign ramp_done = cnt_q == 3'h7;
  assign ctrl_enable = ramp_done;
  // Fault only when the bench asks for one
  assign drive_ready = !fault;
  assign sup_fb = |sig[7:6];
  assign valve_rdy = 1'b1;
  // Bench may hold back pump enable to prove the option gates it
  assign pump_en = run && !pump_block;
endmodule : lds_partner

//--- dv/tb_lds_mapper.sv
module tb_lds_mapper;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, rd_en, wr, flt, pblk;
  logic [4:0] addr;
  logic [31:0] wdata, rd;
  wire logic [31:0] rdata;
  wire logic wreq, ramp, drdy, cen, fb, vrdy, pen, up, dn, fast, r4, star, den, suv;
  wire logic [7:0] sig;
  int failures, samples_checked;
  lds_mapper #(.CYC_PER_MS(4)) DUT (.CLK(clk), .RST_B(rst_b), .AVS_ADDRESS(addr), .AVS_READ(rd_en),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq),
    .RAMP_UP_DONE(ramp), .DRIVE_READY(drdy), .CTRL_ENABLE(cen), .VALVE_SUPERVISION_FEEDBACK(fb),
    .VALVE_READY_STATE(vrdy), .PUMP_ENABLE(pen), .PILOT_RELAY_UP(up), .PILOT_RELAY_DOWN(dn),
    .PILOT_RELAY_FAST(fast), .PILOT_RELAY_SLOW_OR_PUMP_ROLE(r4), .QUICKSTART_RELAY(star),
    .DRIVE_ENABLED(den), .SLOW_UP_VALVE(suv), .CTRL_SIG(sig));
  lds_partner u_far (.clk(clk), .rst_b(rst_b), .run(up | dn), .sig(sig), .fault(flt), .pump_block(pblk),
    .ramp_done(ramp),
    .drive_ready(drdy), .ctrl_enable(cen), .sup_fb(fb), .valve_rdy(vrdy), .pump_en(pen));
  // ==========
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Request stands until the edge that sees waitrequest low; that edge also takes the read word
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd_en <= !w;
    do @(posedge clk); while (wreq !== 1'b0);
    rd = rdata;
    wr <= 1'b0;
    rd_en <= 1'b0;
  endtask : bus
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : tick
  function automatic logic [7:0] esig(input int e, input int d, input int s);
    logic [31:0] ext;
    logic [7:0] fst;
    ext = e ? 32'h0880_0040 : 32'h0880_4210;
    fst = e ? 8'h1C : 8'h7E;
    return (d ? 8'h80 : 8'h40) | 8'(ext[4*s+:4]) | (fst[s] ? (d ? 8'h20 : 8'h10) : 8'h00);
  endfunction : esig
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  // ==========
  // Clock, watchdog, tests
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    finish_test();
  end
  initial begin
    rst_b = 1'b0; rd_en = 1'b0; wr = 1'b0; flt = 1'b0; pblk = 1'b0; addr = 5'h00; wdata = 32'h0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk({up, dn, fast, r4, star, den, suv, sig}, 32'h0);
    for (int a = 0; a < 5; a++) begin
      bus(1'b0, 5'(4 * a), 32'h0);
      chk(rd, 32'h0);
    end
    bus(1'b0, 5'h18, 32'h0);
    chk(rd, 32'h0);
    $display("test reset done");
    bus(1'b1, lds_pkg::LDS_OFS_AFTERRUN, 32'h2);
    bus(1'b1, lds_pkg::LDS_OFS_TRAVEL, 32'h01);
    tick(1);
    chk({den, up}, 2'b10);
    tick(1);
    chk({up, dn, fast, r4, sig}, {4'b1001, 8'h00});
    bus(1'b1, lds_pkg::LDS_OFS_TRAVEL, 32'h12);
    tick(2);
    chk({up, dn, fast, r4, sig}, {4'b0110, 8'h00});
    bus(1'b1, lds_pkg::LDS_OFS_TRAVEL, 32'h03);
    tick(2);
    chk({up, dn, den}, 3'b001);
    tick(14);
    chk(den, 1'b0);
    $display("test pole done");
    for (int e = 0; e < 2; e++) begin
      bus(1'b1, lds_pkg::LDS_OFS_CTRL, 32'(1 + 2 * e));
      for (int k = 0; k < 16; k++) begin
        bus(1'b1, lds_pkg::LDS_OFS_TRAVEL, 32'((k / 2) * 4 + k % 2 + 1));
        tick(2);
        chk({up, dn, sig}, {k % 2 == 0, k % 2 == 1, esig(e, k % 2, k / 2)});
        bus(1'b0, lds_pkg::LDS_OFS_STATUS, 32'h0);
        chk(rd & 32'hFF6, {esig(e, k % 2, k / 2), 4'h6});
      end
    end
    $display("test encoding done");
    for (int g = 0; g < 2; g++) begin
      bus(1'b1, lds_pkg::LDS_OFS_TRAVEL, 32'h0);
      bus(1'b1, lds_pkg::LDS_OFS_CTRL, g ? 32'h81 : 32'h35);
      bus(1'b1, lds_pkg::LDS_OFS_TRAVEL, 32'h05);
      tick(2);
      chk({sig, r4, star}, {8'h00, g == 1, g == 0});
      tick(9);
      chk({sig, r4, star}, {8'h51, 2'b10});
    end
    $display("test gating done");
    bus(1'b1, lds_pkg::LDS_OFS_CTRL, 32'h01);
    bus(1'b1, lds_pkg::LDS_OFS_PUMP_DLY, 32'h2);
    bus(1'b1, lds_pkg::LDS_OFS_VALVE_DLY, 32'h2);
    for (int d = 0; d < 2; d++) begin
      bus(1'b1, lds_pkg::LDS_OFS_TRAVEL, d ? 32'h06 : 32'h05);
      tick(2);
      bus(1'b1, lds_pkg::LDS_OFS_TRAVEL, 32'h0);
      tick(2);
      chk({up, dn, r4, suv}, {2'b00, d == 0, d == 0});
      tick(14);
      chk({r4, suv}, 2'b00);
    end
    $display("test delays done");
    bus(1'b1, lds_pkg::LDS_OFS_CTRL, 32'h41);
    flt <= 1'b1;
    bus(1'b1, lds_pkg::LDS_OFS_TRAVEL, 32'h05);
    tick(2);
    chk({up, sig}, 9'h000);
    bus(1'b0, lds_pkg::LDS_OFS_STATUS, 32'h0);
    chk(rd[0], 1'b1);
    flt <= 1'b0;
    bus(1'b1, lds_pkg::LDS_OFS_STATUS, 32'h1);
    bus(1'b0, lds_pkg::LDS_OFS_STATUS, 32'h0);
    chk(rd[0], 1'b0);
    bus(1'b1, lds_pkg::LDS_OFS_TRAVEL, 32'h0);
    $display("test readiness done");
    bus(1'b1, lds_pkg::LDS_OFS_CTRL, 32'h10D);
    pblk <= 1'b1;
    bus(1'b1, lds_pkg::LDS_OFS_TRAVEL, 32'h05);
    tick(2);
    chk({up, r4, sig}, {2'b11, 8'h00});
    @(posedge clk);
    pblk <= 1'b0;
    tick(2);
    chk(sig, 8'h51);
    bus(1'b1, lds_pkg::LDS_OFS_TRAVEL, 32'h06);
    pblk <= 1'b1;
    tick(12);
    chk({dn, r4, sig}, {2'b10, 8'hA1});
    bus(1'b1, lds_pkg::LDS_OFS_CTRL, 32'h109);
    tick(1);
    chk(r4, 1'b1);
    bus(1'b1, lds_pkg::LDS_OFS_CTRL, 32'h01);
    bus(1'b1, lds_pkg::LDS_OFS_TRAVEL, 32'h05);
    tick(2);
    chk(sig, 8'h51);
    bus(1'b1, lds_pkg::LDS_OFS_TRAVEL, 32'h0);
    pblk <= 1'b0;
    $display("test pump done");
    finish_test();
  end
endmodule : tb_lds_mapper
